//--- hdl/routing_pkg.sv
package routing_pkg;

  // ==========================================================================
  // geometry and register map
  localparam int NBLK = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_BIT = 8;
  localparam logic [ADDR_W-1:0] BANK1_BASE = 12'h100;
  localparam logic [5:0] DATA_IDX_BASE = 6'h20;
  localparam logic [5:0] IN_SEL_IDX [NBLK] = '{6'h21, 6'h25, 6'h29, 6'h2d,
                                               6'h31, 6'h35, 6'h39, 6'h3d};
  localparam logic [5:0] OUT_SEL_IDX [NBLK] = '{6'h22, 6'h26, 6'h2a, 6'h2e,
                                                6'h32, 6'h36, 6'h3a, 6'h3e};
  // word slot inside a block, bank 0
  localparam logic [1:0] SUB_SHIFT_COUNT = 2'h0;
  localparam logic [1:0] SUB_OPERAND_A = 2'h1;
  localparam logic [1:0] SUB_OPERAND_B = 2'h2;
  localparam logic [1:0] SUB_STATUS_CTL = 2'h3;
  // word slot inside a block, bank 1
  localparam logic [1:0] SUB_IN_SEL = 2'h1;
  localparam logic [1:0] SUB_OUT_SEL = 2'h2;

  // ==========================================================================
  // field positions and reset values
  localparam int DATA_SEL_LSB = 4;
  localparam int CLK_SEL_LSB = 0;
  localparam int OUT_SEL_LSB = 0;
  localparam int OUT_EN_BIT = 2;
  localparam int AUX_SEL_LSB = 3;
  localparam int AUX_EN_BIT = 5;
  localparam int BLK_EN_BIT = 0;
  localparam logic [7:0] IN_SEL_RST = 8'h00;
  localparam logic [7:0] OUT_SEL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ==========================================================================
  // source codes: upper two bits pick a group, lower two a line
  localparam logic [1:0] GRP_FIXED = 2'h0;
  localparam logic [1:0] GRP_SYS = 2'h1;
  localparam logic [1:0] GRP_GOUT = 2'h2;
  localparam logic [3:0] D_HIGH = 4'h1;
  localparam logic [3:0] D_BLK3 = 4'h2;
  localparam logic [3:0] D_CHAIN = 4'h3;
  localparam logic [3:0] D_GIN0 = 4'hc;
  localparam logic [3:0] C_XGOUT = 4'h1;
  localparam logic [3:0] C_BLK3 = 4'h2;
  localparam logic [3:0] C_PREV = 4'h3;

  typedef enum logic [3:0] {
    FN_TIMER = 4'h0,
    FN_COUNTER = 4'h1,
    FN_CRC = 4'h2,
    FN_PSEUDO_RANDOM = 4'h3,
    FN_DEADBAND = 4'h4,
    FN_TX_UART = 4'h5,
    FN_RX_UART = 4'h6,
    FN_SPI_MASTER = 4'h7,
    FN_SPI_SLAVE = 4'h8
  } func_e;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic hit;
    logic bank1;
    logic [2:0] blk;
    logic [1:0] sub;
  } reg_dec_s;

  typedef struct packed {
    logic [NBLK-1:0][7:0] in_sel;
    logic [NBLK-1:0][7:0] out_sel;
    logic [NBLK-1:0][7:0] op_a;
    logic [NBLK-1:0][7:0] op_b;
    logic [NBLK-1:0][7:0] stat_ctl;
    logic [7:0] gin_s1;
    logic [7:0] gin_s2;
    logic [3:0] comp_s1;
    logic [3:0] comp_s2;
    logic [7:0] gout;
    logic [7:0] gout_oe;
    logic [7:0] dat;
    logic [7:0] data;
    logic [7:0] capt;
    logic [7:0] chain;
    logic [7:0] ss_n;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    axi_rsp_s rsp;
  } route_state_s;

endpackage

//--- hdl/clk_route.sv
`timescale 1ns/1ns
`default_nettype none

module clk_route
  import routing_pkg::*;
(
  input wire logic [3:0] sel, // clock select code
  input wire logic [3:0] gin_half, // global inputs of this half, raw
  input wire logic [3:0] gout_half, // global outputs of this half
  input wire logic gout_cross, // first global output of the other half
  input wire logic blk3_prim, // primary output of block 3
  input wire logic prev_prim, // primary output of the previous block
  input wire logic [3:0] sys_clk, // system clocks
  output logic clk_out // selected block clock
);

  // ==========================================================================
  // clock mux, pins pass straight through with no resampling
  always_comb begin
    clk_out = 1'b0;
    // R9 - unsynchronised pin clock
    unique case (sel[3:2])
      GRP_FIXED: begin
        if (sel == C_XGOUT) begin
          clk_out = gout_cross;
        end else if (sel == C_BLK3) begin
          clk_out = blk3_prim;
        end else if (sel == C_PREV) begin
          clk_out = prev_prim;
        end
      end
      GRP_SYS: clk_out = sys_clk[sel[1:0]];
      GRP_GOUT: clk_out = gout_half[sel[1:0]];
      default: clk_out = gin_half[sel[1:0]];
    endcase
  end

endmodule

`default_nettype wire

//--- hdl/digital_block_io_routing.sv
// Overview of operation
// R1 - data select field picks block input
// R2 - chain takes data from previous block
// R3 - pin data synchronised to system clock
// R4 - enable, capture edge, serial data, or ignored
// R5 - deadband kill active high, tx ignores
// R6 - rx data, miso or mosi input
// R7 - clock select field picks block clock
// R8 - blocks 0-3 lines 0-3, 4-7 lines 4-7
// R9 - pin clocks pass unsynchronised
// R10 - software votes reads of pin-clocked blocks
// R11 - bit 2 gates primary output
// R12 - primary select n drives line n(+4)
// R13 - bit 5 gates auxiliary output
// R14 - aux select drives or reads line
// R15 - spi slave select from aux input; here blocks 4-7 only, blocks 0-3 hold it high
// R16 - primary output feeds neighbour clock select
// R17 - zero to two outputs per function
// R18 - four software registers per block
// R19 - counter register plus two operands
// R20 - status control holds block enable
// R21 - counter read copies into operand b
// R22 - disabled output leaves line undriven
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module digital_block_io_routing
  import routing_pkg::*;
(
  input wire logic core_clk, // 250 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire axi_req_s axi_req, // axi4-lite master to slave
  output axi_rsp_s axi_rsp, // axi4-lite slave to master
  input wire logic [7:0] gin, // global input bus from pins
  input wire logic [3:0] comp_in, // analog comparator outputs
  input wire logic [3:0] sys_clk, // system clock sources
  input wire func_e [NBLK-1:0] func_mode, // function of each block
  input wire logic [NBLK-1:0] prim_in, // primary output of each block
  input wire logic [NBLK-1:0] aux_in, // auxiliary output of each block
  input wire logic [NBLK-1:0][7:0] shift_count_in, // live counter value
  output logic [7:0] gout, // global output bus value
  output logic [7:0] gout_oe, // global output bus drive enable
  output logic [NBLK-1:0] blk_clk, // selected clock of each block
  output logic [NBLK-1:0] blk_data, // routed data input
  output logic [NBLK-1:0] blk_capture, // timer capture pulse
  output logic [NBLK-1:0] blk_chain, // block chained to previous
  output logic [NBLK-1:0] blk_ss_n, // spi slave select, active low
  output logic [NBLK-1:0] blk_en, // block enable
  output logic [NBLK-1:0][7:0] operand_reg_a, // first operand
  output logic [NBLK-1:0][7:0] operand_reg_b, // second operand
  output logic [NBLK-1:0][7:0] status_control_reg // status and control
);

  route_state_s s;
  route_state_s n;
  logic [7:0] base_d;
  logic [7:0] dat_c;
  logic [3:0] dsel;
  logic [2:0] pl;
  logic [2:0] al;
  logic [7:0] rval;
  reg_dec_s wd;
  reg_dec_s rd;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // helpers
  function automatic reg_dec_s decode(input logic [ADDR_W-1:0] a);
    reg_dec_s d;
    d = '0;
    d.bank1 = a[BANK_BIT];
    d.blk = a[6:4];
    d.sub = a[3:2];
    if (a[11:9] == 3'h0 && a[1:0] == 2'h0 && a[7:2] >= DATA_IDX_BASE) begin
      if (!d.bank1) begin
        d.hit = 1'b1;
      end else begin
        for (int b = 0; b < NBLK; b++) begin
          if (a[7:2] == IN_SEL_IDX[b] || a[7:2] == OUT_SEL_IDX[b]) begin
            d.hit = 1'b1;
          end
        end
      end
    end
    return d;
  endfunction

  function automatic logic uses_data(input func_e f);
    return !(f == FN_PSEUDO_RANDOM || f == FN_TX_UART);
  endfunction

  function automatic logic has_primary(input func_e f);
    return !(f == FN_CRC || f == FN_RX_UART);
  endfunction

  function automatic logic has_aux(input func_e f);
    return !(f == FN_TX_UART || f == FN_RX_UART || f == FN_SPI_SLAVE);
  endfunction

  function automatic logic copies_count(input func_e f);
    return f == FN_TIMER || f == FN_COUNTER || f == FN_CRC ||
           f == FN_PSEUDO_RANDOM || f == FN_DEADBAND;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    n = s;
    base_d = '0;
    dat_c = '0;
    dsel = '0;
    pl = '0;
    al = '0;
    rval = '0;
    wd = decode(s.awaddr);
    rd = decode(axi_req.araddr);

    // R3 - two-stage pin synchronisers
    n.gin_s1 = gin;
    n.gin_s2 = s.gin_s1;
    n.comp_s1 = comp_in;
    n.comp_s2 = s.comp_s1;

    // R1 - data source per block
    for (int b = 0; b < NBLK; b++) begin
      dsel = s.in_sel[b][DATA_SEL_LSB +: 4];
      unique case (dsel[3:2])
        GRP_FIXED: base_d[b] = (dsel == D_HIGH) | ((dsel == D_BLK3) & prim_in[3]);
        GRP_SYS: base_d[b] = s.comp_s2[dsel[1:0]];
        GRP_GOUT: base_d[b] = s.gout[{b[2], dsel[1:0]}];
        default: base_d[b] = s.gin_s2[{b[2], dsel[1:0]}];
      endcase
    end

    // R2 - chained blocks follow the previous block
    n.chain[0] = s.in_sel[0][DATA_SEL_LSB +: 4] == D_CHAIN;
    dat_c[0] = n.chain[0] ? base_d[NBLK-1] : base_d[0];
    for (int b = 1; b < NBLK; b++) begin
      n.chain[b] = s.in_sel[b][DATA_SEL_LSB +: 4] == D_CHAIN;
      dat_c[b] = n.chain[b] ? dat_c[b-1] : base_d[b];
    end

    n.gout = '0;
    n.gout_oe = '0;
    for (int b = 0; b < NBLK; b++) begin
      // R4 - meaning of data depends on function
      // R5 - deadband kill passes, tx uart ignores
      // R6 - serial data passes for rx uart and spi
      n.dat[b] = dat_c[b];
      n.data[b] = uses_data(func_mode[b]) & dat_c[b];
      n.capt[b] = (func_mode[b] == FN_TIMER) & dat_c[b] & !s.dat[b];

      // R8 - block half selects line half
      // R12 - primary select picks line
      pl = {b[2], s.out_sel[b][OUT_SEL_LSB +: 2]};
      al = {b[2], s.out_sel[b][AUX_SEL_LSB +: 2]};
      // R11 - primary gated by enable bit
      // R17 - function decides which outputs exist
      // R22 - disabled outputs leave line undriven
      if (s.out_sel[b][OUT_EN_BIT] && has_primary(func_mode[b])) begin
        n.gout_oe[pl] = 1'b1;
        n.gout[pl] = n.gout[pl] | prim_in[b];
      end
      // R13 - auxiliary gated by enable bit
      // R14 - aux select drives line
      if (s.out_sel[b][AUX_EN_BIT] && has_aux(func_mode[b])) begin
        n.gout_oe[al] = 1'b1;
        n.gout[al] = n.gout[al] | aux_in[b];
      end
      // R15 - upper blocks read slave select
      if (b[2] && func_mode[b] == FN_SPI_SLAVE) begin
        n.ss_n[b] = s.gin_s2[al];
      end else begin
        n.ss_n[b] = 1'b1;
      end
    end

    // ========================================================================
    // axi4-lite write channel, address and data in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.w_got = 1'b1;
      n.wdata = axi_req.wdata[7:0];
      n.wstrb0 = axi_req.wstrb[0];
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = wd.hit ? RESP_OKAY : RESP_SLVERR;
      // R18 - four registers per block plus routing
      if (wd.hit && s.wstrb0) begin
        if (wd.bank1) begin
          if (wd.sub == SUB_IN_SEL) begin
            n.in_sel[wd.blk] = s.wdata;
          end else begin
            n.out_sel[wd.blk] = s.wdata;
          end
        end else begin
          // R19 - counter register is read only here
          unique case (wd.sub)
            SUB_OPERAND_A: n.op_a[wd.blk] = s.wdata;
            SUB_OPERAND_B: n.op_b[wd.blk] = s.wdata;
            SUB_STATUS_CTL: n.stat_ctl[wd.blk] = s.wdata;
            default: ;
          endcase
        end
      end
    end
    n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
    n.rsp.wready = !n.w_got && !n.rsp.bvalid;

    // ========================================================================
    // axi4-lite read channel
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      if (rd.bank1) begin
        rval = (rd.sub == SUB_IN_SEL) ? s.in_sel[rd.blk] : s.out_sel[rd.blk];
      end else begin
        unique case (rd.sub)
          SUB_SHIFT_COUNT: rval = shift_count_in[rd.blk];
          SUB_OPERAND_A: rval = s.op_a[rd.blk];
          SUB_OPERAND_B: rval = s.op_b[rd.blk];
          default: rval = s.stat_ctl[rd.blk];
        endcase
        // R21 - counter read copies into operand b for timer, counter, crc, pseudo random and deadband
        if (rd.hit && rd.sub == SUB_SHIFT_COUNT && copies_count(func_mode[rd.blk])) begin
          n.op_b[rd.blk] = shift_count_in[rd.blk];
        end
      end
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = rd.hit ? RESP_OKAY : RESP_SLVERR;
      n.rsp.rdata = rd.hit ? {24'h000000, rval} : 32'h00000000;
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      for (int b = 0; b < NBLK; b++) begin
        s.in_sel[b] <= IN_SEL_RST;
        s.out_sel[b] <= OUT_SEL_RST;
        s.op_a[b] <= DATA_RST;
        s.op_b[b] <= DATA_RST;
        s.stat_ctl[b] <= DATA_RST;
      end
      s.ss_n <= 8'hff;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // clock selection per block
  for (genvar g = 0; g < NBLK; g++) begin : g_clk
    // R7 - clock select field picks clock
    // R16 - primary output offered as clock
    clk_route u_clk_route (
      .sel(s.in_sel[g][CLK_SEL_LSB +: 4]),
      .gin_half(gin[(g / 4) * 4 +: 4]),
      .gout_half(s.gout[(g / 4) * 4 +: 4]),
      .gout_cross(s.gout[(g < 4) ? 4 : 0]),
      .blk3_prim(prim_in[3]),
      .prev_prim(prim_in[(g + NBLK - 1) % NBLK]),
      .sys_clk(sys_clk),
      .clk_out(blk_clk[g])
    );
  end

  // ==========================================================================
  // outputs
  assign axi_rsp = s.rsp;
  assign gout = s.gout;
  assign gout_oe = s.gout_oe;
  assign blk_data = s.data;
  assign blk_capture = s.capt;
  assign blk_chain = s.chain;
  assign blk_ss_n = s.ss_n;
  assign operand_reg_a = s.op_a;
  assign operand_reg_b = s.op_b;
  assign status_control_reg = s.stat_ctl;
  // R20 - enable bit of status control
  for (genvar g = 0; g < NBLK; g++) begin : g_en
    assign blk_en[g] = s.stat_ctl[g][BLK_EN_BIT];
  end

  // ==========================================================================
  // checks
  a_sync_delay: assert property ( // R3
    (s.in_sel[0][7:4] == D_GIN0 && uses_data(func_mode[0]))
      |=> (s.data[0] == $past(gin[0], 3)))
    else $error("pin data not three cycles behind");

  a_prs_ignore: assert property ( // R4
    (func_mode[3] == FN_PSEUDO_RANDOM) |=> !s.data[3])
    else $error("ignored data input reached block");

  a_capture_pulse: assert property ( // R4
    s.capt[0] |=> !s.capt[0])
    else $error("capture pulse longer than one cycle");

  a_kill_level: assert property ( // R5
    (func_mode[4] == FN_DEADBAND && s.in_sel[4][7:4] == D_HIGH) |=> s.data[4])
    else $error("kill level not passed");

  a_chain_follow: assert property ( // R2
    (s.in_sel[1][7:4] == D_CHAIN && uses_data(func_mode[0]) &&
     uses_data(func_mode[1])) |=> (s.data[1] == s.data[0] && s.chain[1]))
    else $error("chained block lost previous data");

  a_line_undriven: assert property ( // R22
    (s.out_sel == '0) |=> (s.gout_oe == 8'h00))
    else $error("line driven with outputs disabled");

  a_prim_drive: assert property ( // R12
    (s.out_sel[5] == 8'h05 && func_mode[5] == FN_TIMER)
      |=> (s.gout_oe[5] && s.gout[5] == $past(prim_in[5])))
    else $error("primary output not on selected line");

  a_upper_half: assert property ( // R8
    (s.out_sel[7:4] == '0) |=> (s.gout_oe[7:4] == 4'h0))
    else $error("lower block drove upper line");

  a_ss_route: assert property ( // R15
    (func_mode[4] == FN_SPI_SLAVE && s.out_sel[4][4:3] == 2'h0)
      |=> (s.ss_n[4] == $past(s.gin_s2[4])))
    else $error("slave select not routed");

  a_count_copy: assert property ( // R21
    (axi_req.arvalid && s.rsp.arready && axi_req.araddr == 12'h080 &&
     func_mode[0] == FN_TIMER && !(s.aw_got && s.w_got))
      |=> (s.op_b[0] == $past(shift_count_in[0])))
    else $error("counter read did not copy");

endmodule

`default_nettype wire

//--- sim/fn_blocks_model.sv
`timescale 1ns/1ns
`default_nettype none

module fn_blocks_model
  import routing_pkg::*;
#(
  parameter logic [7:0] CNT_SEED = 8'ha5
)
(
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [NBLK-1:0] blk_en, // block enables
  input wire logic [NBLK-1:0] blk_data, // routed data inputs
  input wire logic [NBLK-1:0] prim_drv, // wanted primary levels
  input wire logic [NBLK-1:0] aux_drv, // wanted auxiliary levels
  output logic [NBLK-1:0] prim_in, // primary outputs
  output logic [NBLK-1:0] aux_in, // auxiliary outputs
  output logic [NBLK-1:0][7:0] shift_count_in // live counters
);
  // ==========================================================================
  // function blocks: outputs follow the bench, counters count when enabled and data is high
  always_ff @(posedge core_clk) begin
    prim_in <= prim_drv;
    aux_in <= aux_drv;
    for (int b = 0; b < NBLK; b++) begin
      if (rst) begin
        shift_count_in[b] <= CNT_SEED ^ 8'(b);
      end else if (blk_en[b] && blk_data[b]) begin
        shift_count_in[b] <= shift_count_in[b] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import routing_pkg::*;
;
  localparam logic [7:0] SEED = 8'ha5;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  axi_req_s req = '0;
  axi_rsp_s rsp;
  logic [7:0] gin = 8'h00;
  logic [3:0] sys_clk = 4'h0;
  logic [3:0] comp = 4'h0;
  func_e [NBLK-1:0] fm;
  logic [7:0] prim_drv = 8'h00, aux_drv = 8'h00, prim_in, aux_in, gout, gout_oe;
  logic [7:0] blk_clk, blk_data, blk_capture, blk_chain, blk_ss_n, blk_en;
  logic [NBLK-1:0][7:0] shift_count_in, operand_reg_a, operand_reg_b, status_control_reg;
  logic [33:0] expq[$];
  logic [7:0] v;
  int b, n, l, c, fail_count = 0, check_count = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) sys_clk <= sys_clk + 4'h1;

  fn_blocks_model #(.CNT_SEED(SEED)) partner (.core_clk(core_clk), .rst(rst),
    .blk_en(blk_en), .blk_data(blk_data), .prim_drv(prim_drv), .aux_drv(aux_drv),
    .prim_in(prim_in), .aux_in(aux_in), .shift_count_in(shift_count_in));

  digital_block_io_routing dut (.core_clk(core_clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .gin(gin), .comp_in(comp), .sys_clk(sys_clk), .func_mode(fm),
    .prim_in(prim_in), .aux_in(aux_in), .shift_count_in(shift_count_in), .gout(gout),
    .gout_oe(gout_oe), .blk_clk(blk_clk), .blk_data(blk_data), .blk_capture(blk_capture),
    .blk_chain(blk_chain), .blk_ss_n(blk_ss_n), .blk_en(blk_en),
    .operand_reg_a(operand_reg_a), .operand_reg_b(operand_reg_b),
    .status_control_reg(status_control_reg));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic done(input string s);
    $display("test done: %s", s);
  endtask

  function automatic logic [11:0] dreg(input int bk, input int s);
    return 12'(4 * (32 + 4 * bk + s));
  endfunction

  function automatic logic [11:0] sreg(input int bk, input int s);
    return BANK1_BASE + 12'({(s == 0) ? IN_SEL_IDX[bk] : OUT_SEL_IDX[bk], 2'b00});
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid) begin
        chk(34'(rsp.bresp), 34'(r), "bresp");
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    expq.push_back({r, 24'h0, d});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    @(posedge core_clk);
    while (!rsp.arready) @(posedge core_clk);
    req.arvalid <= 1'b0;
    @(posedge core_clk);
    while (!rsp.rvalid) @(posedge core_clk);
  endtask

  // read results are matched against the oldest note
  always @(posedge core_clk) begin
    if (rsp.rvalid === 1'b1) chk({rsp.rresp, rsp.rdata}, expq.pop_front(), "read");
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #40000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // tests
  initial begin
    for (int i = 0; i < NBLK; i++) fm[i] = FN_TIMER;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hf;
    void'($urandom(26691));
    tick(20);
    rst <= 1'b0;
    tick(1);
    for (b = 0; b < NBLK; b++) begin
      rd(sreg(b, 0), IN_SEL_RST);
      rd(sreg(b, 1), OUT_SEL_RST);
    end
    rd(12'h200, 8'h00, RESP_SLVERR);
    wr(12'h200, 8'hff, RESP_SLVERR);
    done("reset values");
    for (int f = 0; f < 9; f++) begin
      b = f % NBLK;
      v = 8'($urandom);
      fm[b] <= func_e'(f);
      wr(dreg(b, 2), v);
      wr(dreg(b, 0), ~v);
      rd(dreg(b, 0), SEED ^ 8'(b));
      rd(dreg(b, 2), (f < 5) ? SEED ^ 8'(b) : v);
      chk(34'(operand_reg_b[b]), 34'((f < 5) ? SEED ^ 8'(b) : v), "copy");
    end
    done("counter read copy");
    for (b = 0; b < NBLK; b++) begin
      v = 8'($urandom);
      wr(dreg(b, 1), v);
      wr(dreg(b, 3), ~v);
      rd(dreg(b, 1), v);
      rd(dreg(b, 3), ~v);
      chk(34'(blk_en[b]), 34'(v[0] ^ 1'b1), "enable");
      chk(34'(status_control_reg[b]), 34'(v ^ 8'hff), "status");
      chk(34'(operand_reg_a[b]), 34'(v), "operand");
    end
    done("block registers");
    for (int f = 0; f < 9; f++) begin
      b = f % NBLK;
      fm[b] <= func_e'(f);
      wr(sreg(b, 0), {D_HIGH, 4'h0});
      tick(3);
      chk(34'(blk_data[b]), 34'(!(f == FN_PSEUDO_RANDOM || f == FN_TX_UART)), "mode");
    end
    for (int i = 0; i < NBLK; i++) fm[i] <= FN_TIMER;
    done("data per function");
    for (b = 0; b < NBLK; b++) begin
      for (n = 0; n < 4; n++) begin
        l = n + (b / 4) * 4;
        v = 8'($urandom);
        prim_drv <= v;
        aux_drv <= ~v;
        wr(sreg(b, 1), 8'(4 + n));
        tick(3);
        chk(34'(gout_oe), 34'(8'h1 << l), "primary line");
        chk(34'(gout[l]), 34'(v[b]), "primary level");
        wr(sreg(b, 1), 8'(32 + 8 * n));
        tick(3);
        chk(34'(gout_oe), 34'(8'h1 << l), "aux line");
        chk(34'(gout[l]), 34'(v[b] ^ 1'b1), "aux level");
        wr(sreg(b, 1), 8'h1b);
        tick(3);
        chk(34'(gout_oe), 34'(0), "released");
      end
    end
    fm[0] <= FN_CRC;
    wr(sreg(0, 1), 8'h04);
    tick(3);
    chk(34'(gout_oe), 34'(0), "absent primary");
    wr(sreg(0, 1), 8'h00);
    fm[0] <= FN_TIMER;
    done("output routing");
    for (b = 0; b < NBLK; b++) begin
      n = $urandom % 4;
      l = n + (b / 4) * 4;
      wr(sreg(b, 0), 8'((12 + n) << 4));
      gin <= ~(8'h1 << l);
      tick(5);
      gin <= 8'h1 << l;
      tick(2);
      chk(34'(blk_data[b]), 34'(0), "not yet synced");
      tick(3);
      chk(34'(blk_data[b]), 34'(1), "pin data");
    end
    comp <= 4'h5;
    for (b = 0; b < NBLK; b++) begin
      wr(sreg(b, 0), 8'((4 + b % 4) << 4));
      tick(4);
      chk(34'(blk_data[b]), 34'(b % 2 == 0), "comparator");
    end
    done("pin data");
    for (b = 0; b < NBLK; b++) begin
      n = $urandom % 4;
      l = n + (b / 4) * 4;
      prim_drv <= 8'($urandom);
      wr(sreg(b, 0), 8'(12 + n));
      gin <= 8'h1 << l;
      #1 chk(34'(blk_clk[b]), 34'(1), "raw clock");
      @(posedge core_clk);
      gin <= ~(8'h1 << l);
      #1 chk(34'(blk_clk[b]), 34'(0), "clock half");
      @(posedge core_clk);
      wr(sreg(b, 0), C_BLK3);
      #1 chk(34'(blk_clk[b]), 34'(prim_in[3]), "block3 clock");
      @(posedge core_clk);
      wr(sreg(b, 0), C_PREV);
      #1 chk(34'(blk_clk[b]), 34'(prim_in[(b + 7) % 8]), "prev clock");
      @(posedge core_clk);
      wr(sreg(b, 0), 8'(4 + n));
      #1 chk(34'(blk_clk[b]), 34'(sys_clk[n]), "system clock");
      @(posedge core_clk);
    end
    done("clock select");
    wr(sreg(1, 0), {D_CHAIN, 4'h0});
    tick(3);
    chk(34'(blk_chain), 34'(8'h02), "chain");
    wr(sreg(0, 0), {D_GIN0, 4'h0});
    gin <= 8'h00;
    tick(5);
    gin <= 8'h01;
    c = 0;
    repeat (8) begin
      @(posedge core_clk);
      if (blk_capture[0] === 1'b1) c++;
    end
    chk(34'(c), 34'(1), "capture pulses");
    done("chain and capture");
    for (int k = 0; k < 4; k++) begin
      fm[4 + k] <= FN_SPI_SLAVE;
      wr(sreg(4 + k, 1), 8'(8 * k));
      gin <= ~(8'h1 << (4 + k));
      tick(6);
      chk(34'(blk_ss_n), 34'(8'hff ^ (8'h1 << (4 + k))), "select low");
      gin <= 8'hff;
      tick(6);
      chk(34'(blk_ss_n), 34'(8'hff), "select high");
    end
    done("slave select");
    tally_and_finish();
  end
endmodule
`default_nettype wire
